// ### verilog/clkgen_ctrl_defs.svh
// Offsets, field positions, reset value and divider counter width of the control register
`ifndef CLKGEN_CTRL_DEFS_SVH
`define CLKGEN_CTRL_DEFS_SVH

`define CTRL2_OFFSET      32'h0000_0000
`define STATUS_OFFSET     32'h0000_0004
`define ADDR_DECODE_MSB   11
`define CTRL2_RESET       8'h40
`define DIV_CODE_MSB      7
`define DIV_CODE_LSB      6
`define RANGE_BIT         5
`define GAIN_BIT          4
`define LOOP_OFF_BIT      3
`define REF_SRC_BIT       2
`define REF_OUT_EN_BIT    1
`define REF_STOP_KEEP_BIT 0
`define DIV_CNT_W         3

`endif

// ### verilog/clkgen_ctrl_pkg.sv
// Types shared by the bus divider and external reference control block
package clkgen_ctrl_pkg;
    typedef logic [1:0] bus_div_code_t;
    typedef logic [7:0] ctrl_byte_t;
    typedef enum logic [2:0]
    {
        MODE_INTERNAL = 3'b001,
        MODE_EXT_REF  = 3'b010,
        MODE_STOPPED  = 3'b100
    } ref_state_e;
endpackage

// ### verilog/bus_clock_divider.sv
// Divide-by-1/2/4/8 enable generator for the bus clock
`timescale 1ns/1ps
`include "clkgen_ctrl_defs.svh"
module bus_clock_divider
(
    input  wire logic                           hclk,
    input  wire logic                           hresetn,
    input  wire clkgen_ctrl_pkg::bus_div_code_t div_code,
    output logic                                tick
);
    import clkgen_ctrl_pkg::*;

    logic [`DIV_CNT_W-1:0] cnt_r;
    logic [`DIV_CNT_W-1:0] mask;
    logic                  wrap;

    // Terminal count mask per code: 0,1,3,7 for divide by 1,2,4,8
    assign mask = (div_code == 2'h0) ? 3'h0 :
                  (div_code == 2'h1) ? 3'h1 :
                  (div_code == 2'h2) ? 3'h3 : 3'h7;
    assign wrap = ((cnt_r & mask) == mask);

    // Free running counter, tick on wrap
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_r <= 3'h0;
            tick  <= 1'b0;
        end
        else
        begin
            cnt_r <= wrap ? 3'h0 : cnt_r + 3'h1;
            tick  <= wrap;
        end
    end
endmodule

// ### verilog/bus_divider_extref_control.sv
// Bus divider and external reference control register with AHB-Lite slave
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "clkgen_ctrl_defs.svh"
module bus_divider_extref_control
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_ref_clock_in,
    input  wire logic        stop_mode,
    input  wire logic        bypass_mode,
    input  wire logic        ext_ref_engaged_mode,
    input  wire logic        background_debug_active,
    output logic             bus_clock_tick,
    output logic [1:0]       bus_clock_divider,
    output logic             freq_range_high,
    output logic             high_gain_osc_sel,
    output logic             freq_locked_loop_off,
    output logic             ext_ref_source_sel,
    output logic             ext_ref_clock_out,
    output logic             ext_ref_running
);
    import clkgen_ctrl_pkg::*;

    ctrl_byte_t ctrl_r;
    logic       wr_pend_r;
    logic       stop_q1_r, stop_q2_r;
    logic       byp_q1_r, byp_q2_r;
    logic       eng_q1_r, eng_q2_r;
    logic       dbg_q1_r, dbg_q2_r;
    logic       clk_q1_r, clk_q2_r;
    logic       keep_r;
    logic       tick_w;
    logic       addr_ok;
    logic       stat_ok;
    logic       take;
    logic       ref_on;
    logic       keep_nxt;
    logic [31:0] rd_nxt;
    ref_state_e  ref_state_r;
    ref_state_e  ref_state_nxt;

    // Word match on the decoded low address bits
    function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] offs);
        return (a[`ADDR_DECODE_MSB:0] == offs[`ADDR_DECODE_MSB:0]);
    endfunction

    // Address phase decode
    assign take    = hsel & hready & htrans[1];
    assign addr_ok = addr_hit(haddr, `CTRL2_OFFSET);
    assign stat_ok = addr_hit(haddr, `STATUS_OFFSET);

    // Capture address phase; bus always ready, OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
        end
        else if (hready)
        begin
            wr_pend_r <= take & hwrite & addr_ok;
        end
    end

    // Register write in data phase; reset divider code 01
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_r <= `CTRL2_RESET;
        else if (wr_pend_r)
            ctrl_r <= hwdata[7:0];
    end

    // Read mux: control byte, status word, or zero
    assign rd_nxt = !(take & ~hwrite) ? 32'h0 :
                    addr_ok ? {24'h0, ctrl_r} :
                    stat_ok ? {30'h0, ext_ref_running, keep_r} :
                    32'h0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (hready)
            hrdata <= rd_nxt;
    end

    // Fixed zero wait, OKAY response
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Two-stage synchronisers for outside levels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            {stop_q1_r, stop_q2_r} <= 2'b00;
            {byp_q1_r, byp_q2_r}   <= 2'b00;
            {eng_q1_r, eng_q2_r}   <= 2'b00;
            {dbg_q1_r, dbg_q2_r}   <= 2'b00;
            {clk_q1_r, clk_q2_r}   <= 2'b00;
        end
        else
        begin
            stop_q1_r <= stop_mode;
            stop_q2_r <= stop_q1_r;
            byp_q1_r  <= bypass_mode;
            byp_q2_r  <= byp_q1_r;
            eng_q1_r  <= ext_ref_engaged_mode;
            eng_q2_r  <= eng_q1_r;
            dbg_q1_r  <= background_debug_active;
            dbg_q2_r  <= dbg_q1_r;
            clk_q1_r  <= ext_ref_clock_in;
            clk_q2_r  <= clk_q1_r;
        end
    end

    // Keep decision latched while running, frozen during stop
    assign keep_nxt = stop_q2_r ? keep_r :
                      (ctrl_r[`REF_STOP_KEEP_BIT] &
                       (ctrl_r[`REF_OUT_EN_BIT] | eng_q2_r | byp_q2_r));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            keep_r <= 1'b0;
        else
            keep_r <= keep_nxt;
    end

    // Reference state: running, kept through stop, or stopped
    // Entry to stop uses the decision taken in the last running cycle
    always_comb
    begin
        ref_state_nxt = ref_state_r;
        case (ref_state_r)
            MODE_INTERNAL:
                if (stop_q2_r)
                    ref_state_nxt = keep_r ? MODE_EXT_REF : MODE_STOPPED;
            MODE_EXT_REF,
            MODE_STOPPED:
                if (!stop_q2_r)
                    ref_state_nxt = MODE_INTERNAL;
            default:
                ref_state_nxt = MODE_INTERNAL;
        endcase
    end

    // State register, back to running on reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ref_state_r <= MODE_INTERNAL;
        else
            ref_state_r <= ref_state_nxt;
    end

    // Reference runs unless the next state is stopped; no extra cycle of lag
    assign ref_on = (ref_state_nxt != MODE_STOPPED);

    bus_clock_divider u_div
    (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .div_code (ctrl_r[`DIV_CODE_MSB:`DIV_CODE_LSB]),
        .tick     (tick_w)
    );

    // Registered configuration outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_clock_tick       <= 1'b0;
            bus_clock_divider    <= 2'h1;
            freq_range_high      <= 1'b0;
            high_gain_osc_sel    <= 1'b0;
            freq_locked_loop_off <= 1'b0;
            ext_ref_source_sel   <= 1'b0;
            ext_ref_clock_out    <= 1'b0;
            ext_ref_running      <= 1'b0;
        end
        else
        begin
            bus_clock_tick       <= tick_w;
            bus_clock_divider    <= ctrl_r[`DIV_CODE_MSB:`DIV_CODE_LSB];
            freq_range_high      <= ctrl_r[`RANGE_BIT];
            high_gain_osc_sel    <= ctrl_r[`GAIN_BIT];
            freq_locked_loop_off <= ctrl_r[`LOOP_OFF_BIT] & byp_q2_r & ~dbg_q2_r;
            ext_ref_source_sel   <= ctrl_r[`REF_SRC_BIT];
            ext_ref_clock_out    <= clk_q2_r & ctrl_r[`REF_OUT_EN_BIT] & ref_on;
            ext_ref_running      <= ref_on;
        end
    end
endmodule

// ### tb/ctrl_properties.sv
// Port checker for the bus divider and external reference control block
`timescale 1ns/1ps
module ctrl_properties
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       bus_clock_tick,
    input wire logic [1:0] bus_clock_divider,
    input wire logic       bypass_mode,
    input wire logic       background_debug_active,
    input wire logic       freq_locked_loop_off,
    input wire logic       stop_mode,
    input wire logic       ext_ref_running,
    input wire logic       ext_ref_clock_in,
    input wire logic       ext_ref_clock_out
);
    logic [3:0] hot;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // One-hot view of the divider code
    assign hot = 4'h1 << bus_clock_divider;
    // Tick after the code held steady
    sequence s_tk(logic [1:0] c);
        (bus_clock_divider == c)[*3] ##0 bus_clock_tick;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_RESET_DIV: assert property ($rose(hresetn) |-> bus_clock_divider == 2'h1)
        else $error("divider not 01 after reset");
    AST_DIV1: assert property ((bus_clock_divider == 2'h0)[*3] |-> bus_clock_tick)
        else $error("divide by one not steady");
    AST_DIV2: assert property (s_tk(2'h1) |=> (!hot[1] || !bus_clock_tick) ##1
        (!hot[1] || bus_clock_tick)) else $error("divide by two period wrong");
    AST_DIV4: assert property (s_tk(2'h2) |=> (!hot[2] || !bus_clock_tick)[*3] ##1
        (!hot[2] || bus_clock_tick)) else $error("divide by four period wrong");
    AST_DIV8: assert property (s_tk(2'h3) |=> (!hot[3] || !bus_clock_tick)[*7] ##1
        (!hot[3] || bus_clock_tick)) else $error("divide by eight period wrong");
    AST_LOOP_ON: assert property ((!bypass_mode || background_debug_active)[*5]
        |-> !freq_locked_loop_off) else $error("loop off outside bypass");
    AST_RUN: assert property ((!stop_mode)[*5] |-> ext_ref_running)
        else $error("reference stopped outside stop");
    AST_REF_IDLE: assert property ((!ext_ref_clock_in)[*5] |-> !ext_ref_clock_out)
        else $error("reference output without input");
endmodule
bind bus_divider_extref_control ctrl_properties chk_i (.hclk, .hresetn, .hreadyout, .hresp,
    .bus_clock_tick, .bus_clock_divider, .bypass_mode, .background_debug_active,
    .freq_locked_loop_off, .stop_mode, .ext_ref_running, .ext_ref_clock_in, .ext_ref_clock_out);

// ### tb/ext_ref_source.sv
// Free-running external reference clock source
`timescale 1ns/1ps
module ext_ref_source
#(
    parameter int HALF_NS = 100
)
(
    output logic ref_clk
);
    // Oscillator runs free; with HALF_NS = 100 its edges fall on the bench's bus clock edges
    initial ref_clk = 1'b0;
    always #(HALF_NS) ref_clk = ~ref_clk;
endmodule

// ### tb/bus_divider_extref_control_tb.sv
// Self-checking bench for the bus divider and external reference control block
`timescale 1ns/1ps
module bus_divider_extref_control_tb;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic        stop_mode = 1'b0, bypass_mode = 1'b0, ext_ref_engaged_mode = 1'b0;
    logic        background_debug_active = 1'b0, hreadyout, hresp, bus_clock_tick;
    logic        freq_range_high, high_gain_osc_sel, freq_locked_loop_off, ext_ref_source_sel;
    logic        ext_ref_clock_out, ext_ref_running, ext_ref_clock_in;
    logic [1:0]  bus_clock_divider;
    logic [7:0]  v = 8'h11, d;
    int          err_total = 0, cmp_count = 0, n;
    always #4 hclk = ~hclk;
    ext_ref_source src (.ref_clk(ext_ref_clock_in));
    bus_divider_extref_control uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .ext_ref_clock_in, .stop_mode, .bypass_mode, .ext_ref_engaged_mode,
        .background_debug_active, .bus_clock_tick, .bus_clock_divider, .freq_range_high,
        .high_gain_osc_sel, .freq_locked_loop_off, .ext_ref_source_sel, .ext_ref_clock_out,
        .ext_ref_running);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int ratio(input int c);
        return 1 << c;
    endfunction
    // Single word transfer, read data lands in q
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] dt);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= dt;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Cycles between two bus clock ticks
    task automatic per;
        do @(negedge hclk); while (bus_clock_tick !== 1'b1);
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end while (bus_clock_tick !== 1'b1);
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog against a hung run
    initial
    begin
        #100us;
        err_total++;
        results;
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk(32'(bus_clock_divider), 32'h1);
        bus(1'b0, 32'h0, 32'h0);
        chk(q, 32'h40);
        for (int i = 0; i < 4; i++)
        begin
            v = lfsr(v);
            d = {i[1:0], v[5:0]};
            bus(1'b1, 32'h0, {24'h0, d});
            bus(1'b0, 32'h0, 32'h0);
            chk(q, {24'h0, d});
            @(negedge hclk);
            chk({29'h0, freq_range_high, high_gain_osc_sel, ext_ref_source_sel},
                {29'h0, d[5], d[4], d[2]});
            per;
            chk(n, ratio(i));
        end
        bus(1'b0, 32'h10, 32'h0);
        chk(q, 32'h0);
        // Status word: running outside stop, keep decision from the last byte
        bus(1'b0, 32'h4, 32'h0);
        chk(q, {30'h0, 1'b1, d[0] & d[1]});
        bus(1'b1, 32'h0, 32'h08);
        bypass_mode <= 1'b1;
        repeat (6) @(negedge hclk);
        chk(32'(freq_locked_loop_off), 32'h1);
        // Output enable clear: reference output stays quiet
        n = 0;
        repeat (30) @(negedge hclk) n += 32'(ext_ref_clock_out);
        chk(n, 0);
        @(posedge hclk);
        background_debug_active <= 1'b1;
        repeat (6) @(negedge hclk);
        chk(32'(freq_locked_loop_off), 32'h0);
        @(posedge hclk);
        bypass_mode <= 1'b0;
        background_debug_active <= 1'b0;
        bus(1'b1, 32'h0, 32'h02);
        n = 0;
        repeat (100) @(negedge hclk) n += 32'(ext_ref_clock_out);
        chk(32'(n > 10 && n < 90), 32'h1);
        bus(1'b1, 32'h0, 32'h03);
        stop_mode <= 1'b1;
        repeat (6) @(negedge hclk);
        chk(32'(ext_ref_running), 32'h1);
        @(posedge hclk);
        stop_mode <= 1'b0;
        bus(1'b1, 32'h0, 32'h01);
        stop_mode <= 1'b1;
        repeat (6) @(negedge hclk);
        chk(32'(ext_ref_running), 32'h0);
        @(posedge hclk);
        stop_mode <= 1'b0;
        ext_ref_engaged_mode <= 1'b1;
        repeat (6) @(negedge hclk);
        @(posedge hclk);
        stop_mode <= 1'b1;
        repeat (6) @(negedge hclk);
        chk(32'(ext_ref_running), 32'h1);
        // Reset in mid-run brings back the divide-by-two default
        @(posedge hclk);
        stop_mode <= 1'b0;
        ext_ref_engaged_mode <= 1'b0;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk(32'(bus_clock_divider), 32'h1);
        bus(1'b0, 32'h0, 32'h0);
        chk(q, 32'h40);
        results;
    end
endmodule
